// ===== verilog/ttc_pkg.sv
// shared constants for the thermal throttle control block
package ttc_pkg;
  localparam int NUM_CORES = 2;
  localparam int CORE_W = 1;
  localparam int NUM_RANKS = 2;
  localparam int PWR_W = 16;
  localparam int TEMP_W = 8;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 12;
  // register addresses
  localparam logic [ADDR_W-1:0] REG_PKG_FLAGS = 12'h1B1;
  localparam logic [ADDR_W-1:0] REG_THROTTLE = 12'h0A0;
  localparam logic [ADDR_W-1:0] REG_MEM_TEMP_THR = 12'h0A1;
  localparam logic [ADDR_W-1:0] REG_MEM_PWR_LIM = 12'h0A2;
  localparam logic [ADDR_W-1:0] REG_INT_EN = 12'h0A3;
  localparam logic [ADDR_W-1:0] REG_CAPS = 12'h0A4;
  // field positions
  localparam int THR_EN_BIT = 4;
  localparam int DUTY_LSB = 1;
  localparam int DUTY_MSB = 3;
  localparam int CRIT_LIVE_BIT = 4;
  localparam int CRIT_LOG_BIT = 5;
  localparam int INT_EN_BIT = 0;
  localparam int WARM_THR_LSB = 0;
  localparam int HOT_THR_LSB = 8;
  localparam int CLOSED_LOOP_BIT = 16;
  localparam int WARM_PWR_LSB = 0;
  localparam int HOT_PWR_LSB = 16;
  localparam int CAPS_FINE_BIT = 0;
  // capability: 0 means 12.5% steps, 1 means 6.25% steps
  localparam logic CAPS_FINE_GRAIN = 1'b0;
  // reset values
  localparam logic [DATA_W-1:0] RST_ZERO = 64'h0;
  localparam logic [2:0] DUTY_RESERVED = 3'h0;
  // external memory status encoding
  localparam logic [1:0] EXT_WARM = 2'h1;
  localparam int EXT_HOT_BIT = 1;
  // modulation timing
  localparam int MOD_PERIOD_NS = 32000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int HW_ON_PCT = 25;
  localparam int STEPS = 8;
  localparam logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(MOD_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HW_ON_CYC = CNT_W'((MOD_PERIOD_NS / CLK_PERIOD_NS) * HW_ON_PCT / 100);
  localparam logic [CNT_W-1:0] STEP_CYC = CNT_W'((MOD_PERIOD_NS / CLK_PERIOD_NS) / STEPS);
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  typedef enum {TTC_LVL_NONE, TTC_LVL_WARM, TTC_LVL_HOT} ttc_level_e;
endpackage

// ===== verilog/ttc_mod_if.sv
// per-core modulation request and gate between controller and generator
`timescale 1ns/10ps
interface ttc_mod_if;
  logic enable;
  logic [2:0] eighths;
  logic hw_force;
  logic clk_on;
  modport ctrl (output enable, output eighths, output hw_force, input clk_on);
  modport gen (input enable, input eighths, input hw_force, output clk_on);
endinterface

// ===== verilog/ttc_duty_gen.sv
// clock-on gate generator for one core, fixed 32 us period
`timescale 1ns/10ps
module ttc_duty_gen
  import ttc_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  input wire logic resetn,
  ttc_mod_if.gen m
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic on_reg;
  logic on_next;
  logic [CNT_W-1:0] sw_on_cyc;

  // period counts clk cycles at a fixed rate, not core frequency
  always_comb
  begin
    sw_on_cyc = CNT_W'({9'h000, m.eighths} * STEP_CYC); // R21
    cnt_next = (cnt_reg == PERIOD_CYC - CNT_ONE) ? '0 : cnt_reg + CNT_ONE; // R20
    if (m.hw_force)
      on_next = (cnt_reg < HW_ON_CYC); // R19
    else if (m.enable && m.eighths != DUTY_RESERVED)
      on_next = (cnt_reg < sw_on_cyc); // R10
    else
      on_next = 1'b1; // reserved duty runs the clock at full rate
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_reg <= '0;
      on_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      cnt_reg <= cnt_next;
      on_reg <= on_next;
    end
  end

  assign m.clk_on = on_reg;

  a_hw_off_phase: assert property (@(posedge clk) disable iff (!resetn) // R19
    (clk_en && m.hw_force && cnt_reg == HW_ON_CYC) |=> !on_reg)
    else $error("hw modulation on phase longer than a quarter");
  a_period_wrap: assert property (@(posedge clk) disable iff (!resetn) // R20
    (clk_en && cnt_reg == PERIOD_CYC - CNT_ONE) |=> cnt_reg == '0)
    else $error("modulation period length wrong");
endmodule

// ===== verilog/ttc_mem_throttle.sv
// memory traffic throttle level from temperature, status pins or power
`timescale 1ns/10ps
module ttc_mem_throttle
  import ttc_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  input wire logic resetn,
  input wire logic closed_loop,
  input wire logic [TEMP_W-1:0] mem_temp,
  input wire logic [TEMP_W-1:0] warm_thr,
  input wire logic [TEMP_W-1:0] hot_thr,
  input wire logic [1:0] ext_status,
  input wire logic [NUM_RANKS*PWR_W-1:0] rank_power,
  input wire logic [PWR_W-1:0] warm_pwr,
  input wire logic [PWR_W-1:0] hot_pwr,
  output logic [1:0] level
);
  ttc_level_e level_reg;
  ttc_level_e level_next;
  logic warm_c;
  logic hot_c;

  // closed loop uses injected temperature, open loop uses rank power
  always_comb
  begin
    warm_c = (ext_status == EXT_WARM); // R17
    hot_c = ext_status[EXT_HOT_BIT]; // R17
    if (closed_loop)
    begin
      warm_c = warm_c || (mem_temp >= warm_thr); // R16
      hot_c = hot_c || (mem_temp >= hot_thr); // R16
    end
    else
    begin
      for (int r = 0; r < NUM_RANKS; r++)
      begin
        warm_c = warm_c || (rank_power[r*PWR_W +: PWR_W] > warm_pwr); // R18
        hot_c = hot_c || (rank_power[r*PWR_W +: PWR_W] > hot_pwr); // R18
      end
    end
    if (hot_c)
      level_next = TTC_LVL_HOT; // R14
    else if (warm_c)
      level_next = TTC_LVL_WARM;
    else
      level_next = TTC_LVL_NONE;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      level_reg <= TTC_LVL_NONE;
    else if (clk_en)
      level_reg <= level_next;
  end

  assign level = 2'(level_reg);

  a_mem_hot_level: assert property (@(posedge clk) disable iff (!resetn) // R14
    (clk_en && hot_c) |=> level_reg == TTC_LVL_HOT)
    else $error("hot condition did not give hot throttle");
  a_mem_warm_level: assert property (@(posedge clk) disable iff (!resetn) // R14
    (clk_en && warm_c && !hot_c) |=> level_reg == TTC_LVL_WARM)
    else $error("warm condition did not give warm throttle");
endmodule

// ===== verilog/ttc_top.sv
// package thermal throttle control: modulation, alert, trip, memory throttle
//
// Summary of operation
// R1: alert line is released while the package is in deep idle.
// R2: after leaving idle the alert line drives again if still hot.
// R3: sideband temperature reads and injection work in every idle state.
// R4: trip temperature shuts the package down and drives shutdown output.
// R5: hot thermal monitor plus critical temperature latches status and sticky bits.
// R6: critical latch raises the thermal interrupt only when enabled.
// R7: hardware thermal control duty overrides any software duty.
// R8: legacy path duty wins over the per-core register path.
// R9: enable bit of throttle control starts modulation at once.
// R10: duty comes from the three-bit field of throttle control.
// R11: duty steps are 12.5 percent, reported in a capability register.
// R12: per-core register path gates each core independently.
// R13: legacy path gates all cores together.
// R14: memory throttle has warm and hot levels from programmable thresholds.
// R15: software sets warm as intermediate and hot as most severe.
// R16: injected memory temperature from sideband drives closed-loop throttling.
// R17: two-line external memory status input carries status only.
// R18: without sensor, per-rank power above limits triggers throttling.
// R19: hardware modulation is fixed at 25 percent on, 75 percent off.
// R20: hardware modulation period is 32 us, independent of core frequency.
// R21: duty value N gives N eighths on time; zero is reserved.
`timescale 1ns/10ps
module ttc_top
  import ttc_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  input wire logic resetn,
  input wire logic [ttc_pkg::NUM_CORES-1:0] core_at_tcc,
  input wire logic crit_temp_hit,
  input wire logic trip_temp_hit,
  input wire logic pkg_deep_idle,
  input wire logic [ttc_pkg::TEMP_W-1:0] pkg_temp,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ttc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ttc_pkg::CORE_W-1:0] reg_core,
  input wire logic [ttc_pkg::DATA_W-1:0] reg_wdata,
  output logic [ttc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic legacy_wr,
  input wire logic [4:0] legacy_wdata,
  input wire logic sb_rd,
  output logic [ttc_pkg::TEMP_W-1:0] sb_rdata,
  output logic sb_rvalid,
  input wire logic sb_mem_temp_wr,
  input wire logic [ttc_pkg::TEMP_W-1:0] sb_mem_temp,
  input wire logic [1:0] external_mem_temp_status,
  input wire logic [ttc_pkg::NUM_RANKS*ttc_pkg::PWR_W-1:0] rank_power,
  output logic [ttc_pkg::NUM_CORES-1:0] core_clk_en,
  output logic thermal_alert_line_n_out,
  output logic thermal_alert_line_oe,
  output logic overtemp_shutdown_out_n,
  output logic pkg_shutdown,
  output logic therm_int,
  output logic [1:0] mem_throttle_level
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [4:0] throttle_reg [NUM_CORES];
  logic [4:0] throttle_next [NUM_CORES];
  logic [4:0] legacy_reg;
  logic [4:0] legacy_next;
  logic [DATA_W-1:0] mem_thr_reg;
  logic [DATA_W-1:0] mem_thr_next;
  logic [DATA_W-1:0] mem_pwr_reg;
  logic [DATA_W-1:0] mem_pwr_next;
  logic int_en_reg;
  logic int_en_next;
  logic crit_live_reg;
  logic crit_live_next;
  logic crit_log_reg;
  logic crit_log_next;
  logic int_reg;
  logic int_next;
  logic trip_reg;
  logic trip_next;
  logic alert_oe_reg;
  logic alert_oe_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [TEMP_W-1:0] sb_rdata_reg;
  logic [TEMP_W-1:0] sb_rdata_next;
  logic sb_rvalid_reg;
  logic sb_rvalid_next;
  logic [TEMP_W-1:0] mem_temp_reg;
  logic [TEMP_W-1:0] mem_temp_next;
  logic [1:0] ext_meta_reg;
  logic [1:0] ext_sync_reg;
  logic tcc_active;
  logic crit_cond;
  logic [1:0] mem_level;
  logic [NUM_CORES-1:0] gate_on;
  logic flags_wr;
  logic thr_wr;

  assign tcc_active = |core_at_tcc;
  assign crit_cond = tcc_active && crit_temp_hit; // R5
  assign flags_wr = reg_wr && reg_addr == REG_PKG_FLAGS;
  assign thr_wr = reg_wr && reg_addr == REG_THROTTLE;

  ////////////////////////////////////////////////////////////////////////////
  // external memory status pins cross in through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_meta_reg <= 2'h0;
      ext_sync_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      ext_meta_reg <= external_mem_temp_status;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers written by software
  always_comb
  begin
    for (int c = 0; c < NUM_CORES; c++)
    begin
      throttle_next[c] = throttle_reg[c];
      if (thr_wr && reg_core == CORE_W'(c))
        throttle_next[c] = {1'b0, reg_wdata[THR_EN_BIT:DUTY_LSB]}; // R9 R12
    end
    legacy_next = legacy_wr ? {1'b0, legacy_wdata[THR_EN_BIT:DUTY_LSB]} : legacy_reg; // R13
    mem_thr_next = mem_thr_reg;
    mem_pwr_next = mem_pwr_reg;
    int_en_next = int_en_reg;
    if (reg_wr && reg_addr == REG_MEM_TEMP_THR)
      mem_thr_next = reg_wdata; // R14
    if (reg_wr && reg_addr == REG_MEM_PWR_LIM)
      mem_pwr_next = reg_wdata; // R18
    if (reg_wr && reg_addr == REG_INT_EN)
      int_en_next = reg_wdata[INT_EN_BIT]; // R6
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int c = 0; c < NUM_CORES; c++)
        throttle_reg[c] <= 5'h00;
      legacy_reg <= 5'h00;
      mem_thr_reg <= RST_ZERO;
      mem_pwr_reg <= RST_ZERO;
      int_en_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      for (int c = 0; c < NUM_CORES; c++)
        throttle_reg[c] <= throttle_next[c];
      legacy_reg <= legacy_next;
      mem_thr_reg <= mem_thr_next;
      mem_pwr_reg <= mem_pwr_next;
      int_en_reg <= int_en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // critical temperature status, sticky log and interrupt
  // the log bit is cleared by writing zero; a new event in that cycle wins
  always_comb
  begin
    crit_live_next = crit_cond; // R5
    crit_log_next = crit_log_reg;
    if (flags_wr && !reg_wdata[CRIT_LOG_BIT])
      crit_log_next = 1'b0;
    if (crit_cond)
      crit_log_next = 1'b1; // R5
    int_next = int_en_reg && crit_cond && !crit_live_reg; // R6
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      crit_live_reg <= 1'b0;
      crit_log_reg <= 1'b0;
      int_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      crit_live_reg <= crit_live_next;
      crit_log_reg <= crit_log_next;
      int_reg <= int_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trip latch and alert line; trip holds until reset since the package is off
  always_comb
  begin
    trip_next = trip_reg || trip_temp_hit; // R4
    // released in deep idle, recomputed from live state on wake
    alert_oe_next = tcc_active && !pkg_deep_idle; // R1 R2
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trip_reg <= 1'b0;
      alert_oe_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      trip_reg <= trip_next;
      alert_oe_reg <= alert_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, one cycle after the strobe
  always_comb
  begin
    rdata_next = RST_ZERO;
    rvalid_next = reg_rd;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_PKG_FLAGS:
        begin
          rdata_next[CRIT_LIVE_BIT] = crit_live_reg;
          rdata_next[CRIT_LOG_BIT] = crit_log_reg;
        end
        REG_THROTTLE:
          rdata_next[THR_EN_BIT:DUTY_LSB] = throttle_reg[reg_core][THR_EN_BIT - DUTY_LSB:0];
        REG_MEM_TEMP_THR:
          rdata_next = mem_thr_reg;
        REG_MEM_PWR_LIM:
          rdata_next = mem_pwr_reg;
        REG_INT_EN:
          rdata_next[INT_EN_BIT] = int_en_reg;
        REG_CAPS:
          rdata_next[CAPS_FINE_BIT] = CAPS_FINE_GRAIN; // R11
        default:
          rdata_next = RST_ZERO; // unmapped reads return zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= RST_ZERO;
      rvalid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sideband link: no idle gating, platform polls it while the cores sleep
  always_comb
  begin
    sb_rvalid_next = sb_rd; // R3
    sb_rdata_next = sb_rd ? pkg_temp : sb_rdata_reg;
    mem_temp_next = sb_mem_temp_wr ? sb_mem_temp : mem_temp_reg; // R16
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sb_rvalid_reg <= 1'b0;
      sb_rdata_reg <= 8'h00;
      mem_temp_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      sb_rvalid_reg <= sb_rvalid_next;
      sb_rdata_reg <= sb_rdata_next;
      mem_temp_reg <= mem_temp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-core modulation select: hardware, then legacy, then per-core setting
  genvar g;
  generate
    for (g = 0; g < NUM_CORES; g++)
    begin : g_core
      ttc_mod_if mif ();
      assign mif.hw_force = tcc_active; // R7
      assign mif.enable = legacy_reg[THR_EN_BIT - DUTY_LSB] ||
        throttle_reg[g][THR_EN_BIT - DUTY_LSB]; // R9
      assign mif.eighths = legacy_reg[THR_EN_BIT - DUTY_LSB] ?
        legacy_reg[DUTY_MSB - DUTY_LSB:0] : // R8 R13
        throttle_reg[g][DUTY_MSB - DUTY_LSB:0]; // R10 R12
      assign gate_on[g] = mif.clk_on;
      ttc_duty_gen u_gen (
        .clk(clk),
        .clk_en(clk_en),
        .resetn(resetn),
        .m(mif)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // memory throttle level
  ttc_mem_throttle u_mem (
    .clk(clk),
    .clk_en(clk_en),
    .resetn(resetn),
    .closed_loop(mem_thr_reg[CLOSED_LOOP_BIT]),
    .mem_temp(mem_temp_reg),
    .warm_thr(mem_thr_reg[WARM_THR_LSB +: TEMP_W]),
    .hot_thr(mem_thr_reg[HOT_THR_LSB +: TEMP_W]),
    .ext_status(ext_sync_reg),
    .rank_power(rank_power),
    .warm_pwr(mem_pwr_reg[WARM_PWR_LSB +: PWR_W]),
    .hot_pwr(mem_pwr_reg[HOT_PWR_LSB +: PWR_W]),
    .level(mem_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each from a flop except the alert line data, which is tied low
  assign core_clk_en = gate_on;
  assign thermal_alert_line_n_out = 1'b0; // open drain: only low is driven
  assign thermal_alert_line_oe = alert_oe_reg;
  assign overtemp_shutdown_out_n = !trip_reg;
  assign pkg_shutdown = trip_reg;
  assign therm_int = int_reg;
  assign mem_throttle_level = mem_level;
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign sb_rdata = sb_rdata_reg;
  assign sb_rvalid = sb_rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_idle_release: assert property (@(posedge clk) disable iff (!resetn) // R1
    (clk_en && pkg_deep_idle) |=> !thermal_alert_line_oe)
    else $error("alert driven during deep idle");
  a_wake_realert: assert property (@(posedge clk) disable iff (!resetn) // R2
    (clk_en && $fell(pkg_deep_idle) && tcc_active) |=> thermal_alert_line_oe)
    else $error("alert not driven again on wake while hot");
  a_trip_stays: assert property (@(posedge clk) disable iff (!resetn) // R4
    (clk_en && trip_temp_hit) |=> !overtemp_shutdown_out_n [*4])
    else $error("shutdown output not held after trip");
  a_crit_sticky: assert property (@(posedge clk) disable iff (!resetn) // R5
    (clk_en && crit_cond) |=> crit_log_reg && crit_live_reg)
    else $error("critical status not latched");
  a_int_gated: assert property (@(posedge clk) disable iff (!resetn) // R6
    therm_int |-> $past(int_en_reg) && $past(crit_cond))
    else $error("interrupt without enable or cause");
  a_hw_override: assert property (@(posedge clk) disable iff (!resetn) // R7
    (clk_en && tcc_active && g_core[0].u_gen.cnt_reg >= HW_ON_CYC) |=> !core_clk_en[0])
    else $error("software duty not overridden");
  a_legacy_wins: assert property (@(posedge clk) disable iff (!resetn) // R8
    legacy_reg[THR_EN_BIT - DUTY_LSB] |->
      g_core[0].mif.eighths == legacy_reg[DUTY_MSB - DUTY_LSB:0])
    else $error("legacy duty did not take precedence");
  a_sb_answer: assert property (@(posedge clk) disable iff (!resetn) // R3
    (clk_en && sb_rd) |=> sb_rvalid && sb_rdata == $past(pkg_temp))
    else $error("sideband read not answered");
endmodule

// ===== sim/ttc_ec_model.sv
// platform controller model on the sideband thermal link
`timescale 1ns/10ps
module ttc_ec_model
  import ttc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic poll_en,
  input wire logic sb_rvalid,
  input wire logic [ttc_pkg::TEMP_W-1:0] sb_rdata,
  output logic sb_rd,
  output logic sb_mem_temp_wr,
  output logic [ttc_pkg::TEMP_W-1:0] sb_mem_temp,
  output logic [ttc_pkg::TEMP_W-1:0] last_temp,
  output int polls
);
  int gap;
  initial
  begin
    sb_rd = 1'b0;
    sb_mem_temp_wr = 1'b0;
    sb_mem_temp = 8'h00;
    last_temp = 8'h00;
    polls = 0;
    gap = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // poll every 16 cycles, idle or not, so idle residency never hides heat
  always @(negedge clk)
  begin
    if (!resetn || !poll_en)
    begin
      sb_rd <= 1'b0;
      gap <= 0;
    end
    else
    begin
      gap <= (gap == 15) ? 0 : gap + 1;
      sb_rd <= (gap == 15);
    end
  end
  // answer is a one-cycle pulse, so catch it on the edge it stands at
  always @(posedge clk)
  begin
    if (sb_rvalid === 1'b1)
    begin
      last_temp <= sb_rdata;
      polls <= polls + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // inject one memory temperature, then drive the inverse so stale data shows
  task automatic inject(input logic [TEMP_W-1:0] v);
    @(negedge clk);
    sb_mem_temp_wr = 1'b1;
    sb_mem_temp = v;
    @(negedge clk);
    sb_mem_temp_wr = 1'b0;
    sb_mem_temp = ~v;
  endtask
endmodule

// ===== sim/test_thermal_throttle_control.sv
// self-checking bench for the thermal throttle control block
`timescale 1ns/10ps
module test_thermal_throttle_control;
  import ttc_pkg::*;
  // one modulation period of 32 us at 8 ns
  localparam int PER = 32000 / 8;
  logic clk, clk_en, resetn, crit_temp_hit, trip_temp_hit, pkg_deep_idle, poll_en;
  logic reg_wr, reg_rd, reg_rvalid, legacy_wr, sb_rd, sb_rvalid, sb_mem_temp_wr;
  logic thermal_alert_line_oe, overtemp_shutdown_out_n, pkg_shutdown, therm_int;
  logic [NUM_CORES-1:0] core_at_tcc, core_clk_en;
  logic [TEMP_W-1:0] pkg_temp, sb_rdata, sb_mem_temp, last_temp;
  logic [ADDR_W-1:0] reg_addr;
  logic [CORE_W-1:0] reg_core;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [4:0] legacy_wdata;
  logic [1:0] external_mem_temp_status, mem_throttle_level;
  logic [NUM_RANKS*PWR_W-1:0] rank_power;
  int polls, err_total, num_checks;

  ttc_top i_ttc_top (.clk(clk), .clk_en(clk_en), .resetn(resetn), .core_at_tcc(core_at_tcc),
    .crit_temp_hit(crit_temp_hit), .trip_temp_hit(trip_temp_hit),
    .pkg_deep_idle(pkg_deep_idle), .pkg_temp(pkg_temp), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_core(reg_core), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .legacy_wr(legacy_wr), .legacy_wdata(legacy_wdata),
    .sb_rd(sb_rd), .sb_rdata(sb_rdata), .sb_rvalid(sb_rvalid),
    .sb_mem_temp_wr(sb_mem_temp_wr), .sb_mem_temp(sb_mem_temp),
    .external_mem_temp_status(external_mem_temp_status), .rank_power(rank_power),
    .core_clk_en(core_clk_en), .thermal_alert_line_n_out(),
    .thermal_alert_line_oe(thermal_alert_line_oe),
    .overtemp_shutdown_out_n(overtemp_shutdown_out_n), .pkg_shutdown(pkg_shutdown),
    .therm_int(therm_int), .mem_throttle_level(mem_throttle_level));

  ttc_ec_model i_ttc_ec_model (.clk(clk), .resetn(resetn), .poll_en(poll_en),
    .sb_rvalid(sb_rvalid), .sb_rdata(sb_rdata), .sb_rd(sb_rd),
    .sb_mem_temp_wr(sb_mem_temp_wr), .sb_mem_temp(sb_mem_temp), .last_temp(last_temp),
    .polls(polls));

  ////////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, well beyond the few modulation windows measured
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic compare(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // strobes last one cycle, sampled on the rising edge between two falling edges
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [CORE_W-1:0] c,
                           input logic [63:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_core = c;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic reg_check(input logic [ADDR_W-1:0] a, input logic [CORE_W-1:0] c,
                           input logic [63:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    reg_core = c;
    @(negedge clk);
    reg_rd = 1'b0;
    compare("read valid", 64'(reg_rvalid), 64'h1);
    compare("read data", reg_rdata, exp);
  endtask
  task automatic legacy_write(input logic [4:0] d);
    @(negedge clk);
    legacy_wr = 1'b1;
    legacy_wdata = d;
    @(negedge clk);
    legacy_wr = 1'b0;
  endtask
  // any full period holds each counter value once, so phase does not matter
  task automatic count_on(input int e0, input int e1);
    int n0 = 0;
    int n1 = 0;
    repeat (2) @(negedge clk);
    repeat (PER)
    begin
      @(negedge clk);
      n0 += (core_clk_en[0] === 1'b1);
      n1 += (core_clk_en[1] === 1'b1);
    end
    compare("core0 on cycles", 64'(n0), 64'(e0));
    compare("core1 on cycles", 64'(n1), 64'(e1));
  endtask
  task automatic int_pulses(input int exp);
    int n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += (therm_int === 1'b1);
    end
    compare("interrupt pulses", 64'(n), 64'(exp));
  endtask
  // status pins pass two sync flops before the level register
  task automatic level_is(input logic [1:0] exp);
    repeat (5) @(negedge clk);
    compare("memory throttle level", 64'(mem_throttle_level), 64'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    num_checks = 0;
    clk_en = 1'b1;
    resetn = 1'b0;
    core_at_tcc = 2'b00;
    crit_temp_hit = 1'b0;
    trip_temp_hit = 1'b0;
    pkg_deep_idle = 1'b0;
    pkg_temp = 8'h5A;
    poll_en = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_core = 1'b0;
    reg_wdata = 64'h0;
    legacy_wr = 1'b0;
    legacy_wdata = 5'h00;
    external_mem_temp_status = 2'h0;
    rank_power = 32'h0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    compare("core clocks at reset", 64'(core_clk_en), 64'h3);
    compare("shutdown at reset", 64'(overtemp_shutdown_out_n), 64'h1);
    reg_check(REG_CAPS, 1'b0, 64'h0);
    reg_write(12'h123, 1'b0, 64'hFF);
    reg_check(12'h123, 1'b0, 64'h0);
    // per-core path: core0 at four eighths, core1 untouched
    reg_write(REG_THROTTLE, 1'b0, 64'h18);
    reg_check(REG_THROTTLE, 1'b0, 64'h18);
    reg_check(REG_THROTTLE, 1'b1, 64'h0);
    count_on(4 * PER / 8, PER);
    // legacy path at two eighths wins and gates both cores
    legacy_write(5'h14);
    count_on(2 * PER / 8, 2 * PER / 8);
    // hardware control overrides six eighths with its fixed quarter
    legacy_write(5'h1C);
    core_at_tcc = 2'b01;
    count_on(PER / 4, PER / 4);
    compare("alert while hot", 64'(thermal_alert_line_oe), 64'h1);
    pkg_deep_idle = 1'b1;
    poll_en = 1'b1;
    repeat (40) @(negedge clk);
    compare("alert in deep idle", 64'(thermal_alert_line_oe), 64'h0);
    compare("sideband temperature", 64'(last_temp), 64'h5A);
    pkg_deep_idle = 1'b0;
    repeat (2) @(negedge clk);
    compare("alert after wake", 64'(thermal_alert_line_oe), 64'h1);
    // critical temperature: live and sticky bits, gated interrupt
    reg_write(REG_INT_EN, 1'b0, 64'h1);
    crit_temp_hit = 1'b1;
    int_pulses(1);
    reg_check(REG_PKG_FLAGS, 1'b0, 64'h30);
    crit_temp_hit = 1'b0;
    repeat (2) @(negedge clk);
    reg_check(REG_PKG_FLAGS, 1'b0, 64'h20);
    reg_write(REG_PKG_FLAGS, 1'b0, 64'h0);
    reg_check(REG_PKG_FLAGS, 1'b0, 64'h0);
    reg_write(REG_INT_EN, 1'b0, 64'h0);
    crit_temp_hit = 1'b1;
    int_pulses(0);
    crit_temp_hit = 1'b0;
    core_at_tcc = 2'b00;
    // closed loop: warm 0x28, hot 0x50, injected over the sideband link
    reg_write(REG_MEM_TEMP_THR, 1'b0, 64'h1_5028);
    i_ttc_ec_model.inject(8'h32);
    level_is(2'h1);
    i_ttc_ec_model.inject(8'h5A);
    level_is(2'h2);
    i_ttc_ec_model.inject(8'h0A);
    level_is(2'h0);
    external_mem_temp_status = 2'h1;
    level_is(2'h1);
    external_mem_temp_status = 2'h2;
    level_is(2'h2);
    external_mem_temp_status = 2'h0;
    // open loop: per-rank power against warm 100 and hot 200
    reg_write(REG_MEM_TEMP_THR, 1'b0, 64'h5028);
    reg_write(REG_MEM_PWR_LIM, 1'b0, 64'h00C8_0064);
    rank_power = {16'h0096, 16'h0000};
    level_is(2'h1);
    rank_power = {16'h0000, 16'h00FA};
    level_is(2'h2);
    rank_power = 32'h0;
    level_is(2'h0);
    // trip latches shutdown until reset
    trip_temp_hit = 1'b1;
    @(negedge clk);
    trip_temp_hit = 1'b0;
    repeat (3) @(negedge clk);
    compare("shutdown output", 64'(overtemp_shutdown_out_n), 64'h0);
    compare("package shutdown", 64'(pkg_shutdown), 64'h1);
    tally_and_finish();
  end
endmodule
